// ---- verilog/fde_pkg.sv ----
// shared constants of the floppy disk emulator with drive noise
package fde_pkg;

    // ------------------------------------------------------------------
    // clock and timing
    // ------------------------------------------------------------------
    localparam int unsigned CLK_PERIOD_NS = 40;
    localparam int unsigned CLICK_TIME_NS = 2_000_000;
    localparam int unsigned CLICK_CYC     =
        (CLICK_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // system cycles per flash bit; one shift per bit
    localparam int unsigned SPI_BIT_CYC   = 8;

    // ------------------------------------------------------------------
    // processor address decode
    // ------------------------------------------------------------------
    localparam logic [15:0] SLOT_IO_BASE   = 16'hc0e0;
    localparam logic [15:0] SLOT_IO_MASK   = 16'hfff0;
    localparam logic [15:0] DISK_DATA_ADDR = 16'hc0ec;
    localparam logic [15:0] SPK_ADDR       = 16'hc030;
    localparam logic [15:0] SPK_MASK       = 16'hfff0;
    localparam int unsigned LATCH_SEL_HI   = 3;
    localparam int unsigned LATCH_SEL_LO   = 1;
    localparam int unsigned LATCH_VAL_BIT  = 0;

    // ------------------------------------------------------------------
    // latch bit layout
    // ------------------------------------------------------------------
    localparam int unsigned PHASE_HI    = 3;
    localparam int unsigned LATCH_MOTOR = 4;
    localparam logic [7:0]  LATCH_RESET = 8'h00;

    // ------------------------------------------------------------------
    // track layout and flash reader
    // ------------------------------------------------------------------
    localparam int unsigned SECTORS       = 16;
    localparam int unsigned SECTOR_BYTES  = 374;
    localparam int unsigned TRACK_W       = 6;
    localparam int unsigned POS_W         = TRACK_W + 1;
    localparam int unsigned TRACK_LAST    = 34;
    localparam int unsigned ADDR_W        = 24;
    localparam logic [ADDR_W-1:0] TRACK_BYTES   = 24'h001760;
    localparam logic [ADDR_W-1:0] FLASH_BASE    = 24'h000000;
    localparam logic [7:0]  FLASH_READ_CMD      = 8'h03;
    localparam int unsigned CMD_BITS      = 32;
    localparam int unsigned BYTE_BITS     = 8;
    localparam int unsigned BITCNT_W      = 6;
    localparam int unsigned BYTECNT_W     = 13;
    localparam logic [BITCNT_W-1:0]  CMD_LAST  = 6'h1f;
    localparam logic [BITCNT_W-1:0]  BYTE_LAST = 6'h07;
    localparam logic [BYTECNT_W-1:0] TRACK_BYTE_CNT = 13'h1760;

    // ------------------------------------------------------------------
    // mixer and noise
    // ------------------------------------------------------------------
    localparam int unsigned MIX_W          = 5;
    localparam logic [4:0]  MIX_TRACK_LAST = 5'h01;
    localparam logic [4:0]  MIX_SPIN       = 5'h02;
    localparam logic [4:0]  MIX_LAST       = 5'h1f;
    localparam int unsigned LFSR_W         = 12;
    localparam logic [11:0] LFSR_SEED      = 12'h001;
    localparam logic [11:0] LFSR_TAPS      = 12'h829;
    localparam logic [2:0]  LFSR_RUN_STEPS = 3'h5;

endpackage

// ---- verilog/fde_track_counter.sv ----
// head position tracker driven by the four stepper phases
`timescale 1ns/1ps

module fde_track_counter
    import fde_pkg::*;
#(
    parameter int unsigned TRACK_MAX = TRACK_LAST
)
(
    // clock and reset
    input  wire logic              clk_sys,
    input  wire logic              reset,
    // stepper phases from the latch
    input  wire logic [PHASE_HI:0] phases,
    // track position toward the reader
    output logic      [TRACK_W-1:0] track_num,
    output logic      [ADDR_W-1:0]  flash_addr,
    output logic                    new_track
);

    localparam logic [POS_W-1:0] POS_MAX = POS_W'(2 * TRACK_MAX);

    typedef struct packed {
        logic [POS_W-1:0]  pos;
        logic [ADDR_W-1:0] addr;
        logic              new_trk;
    } fde_trk_state_t;

    fde_trk_state_t cur;
    fde_trk_state_t nxt;
    logic [1:0]     ph_idx;
    logic           fwd;
    logic           back;

    always_comb
    begin
        nxt    = cur;
        ph_idx = cur.pos[1:0];
        fwd    = phases[ph_idx + 2'h1];
        back   = phases[ph_idx - 2'h1];
        // half-track steps; even positions rest on phase zero or two
        if (fwd && !back && cur.pos != POS_MAX)
        begin
            nxt.pos = cur.pos + 1'b1; // see [R3]
        end
        else if (back && !fwd && cur.pos != '0)
        begin
            nxt.pos = cur.pos - 1'b1; // see [R3]
        end
        nxt.new_trk = nxt.pos[POS_W-1:1] != cur.pos[POS_W-1:1]; // see [R4]
        if (nxt.new_trk)
        begin
            if (nxt.pos > cur.pos)
            begin
                nxt.addr = cur.addr + TRACK_BYTES; // see [R5]
            end
            else
            begin
                nxt.addr = cur.addr - TRACK_BYTES; // see [R5]
            end
        end
    end

    always_ff @(posedge clk_sys or posedge reset)
    begin
        if (reset)
        begin
            cur <= '{pos: '0, addr: FLASH_BASE, new_trk: 1'b0}; // see [R20]
        end
        else
        begin
            cur <= nxt;
        end
    end

    assign track_num  = cur.pos[POS_W-1:1];
    assign flash_addr = cur.addr;
    assign new_track  = cur.new_trk;

endmodule

// ---- verilog/fde_flash_reader.sv ----
// serial flash reader that streams track bytes one at a time
`timescale 1ns/1ps

module fde_flash_reader
    import fde_pkg::*;
#(
    parameter int unsigned BIT_CYC = SPI_BIT_CYC
)
(
    // clock and reset
    input  wire logic              clk_sys,
    input  wire logic              reset,
    // request side
    input  wire logic              rd_req,
    input  wire logic [ADDR_W-1:0] start_addr,
    input  wire logic              resume,
    output logic      [7:0]        data_byte,
    output logic                   byte_ready,
    // flash pins
    output logic                   spi_ss_n,
    output logic                   spi_sck,
    output logic                   spi_mosi,
    input  wire logic              spi_miso
);

    localparam int unsigned PH_W = (BIT_CYC > 1) ? $clog2(BIT_CYC) : 1;
    localparam logic [PH_W-1:0] PH_LAST = PH_W'(BIT_CYC - 1);
    localparam logic [PH_W-1:0] PH_HALF = PH_W'(BIT_CYC / 2);

    typedef enum logic [1:0] {
        FDE_RD_IDLE  = 2'b00,
        FDE_RD_SHIFT = 2'b01,
        FDE_RD_HALT  = 2'b10
    } fde_rd_st_t;

    typedef struct packed {
        fde_rd_st_t           st;
        logic [CMD_BITS-1:0]  sr;
        logic [PH_W-1:0]      ph;
        logic [BITCNT_W-1:0]  bits;
        logic [BYTECNT_W-1:0] bytes;
        logic                 cmd_done;
        logic                 rdy;
        logic                 ss_n;
        logic                 sck;
        logic                 mosi;
        logic                 miso_meta;
        logic                 miso_sync;
    } fde_rd_state_t;

    fde_rd_state_t cur;
    fde_rd_state_t nxt;
    logic          restart;

    always_comb
    begin
        nxt           = cur;
        nxt.miso_meta = spi_miso;
        nxt.miso_sync = cur.miso_meta;
        // whole track consumed: start over from the same track start
        restart = cur.st == FDE_RD_HALT && resume
                  && cur.bytes == TRACK_BYTE_CNT; // see [R11] see [R6]
        if (rd_req || restart)
        begin
            nxt.st       = FDE_RD_SHIFT;
            nxt.sr       = {FLASH_READ_CMD, start_addr}; // see [R7]
            nxt.ss_n     = 1'b1; // see [R7]
            nxt.ph       = '0;
            nxt.bits     = '0;
            nxt.bytes    = '0;
            nxt.cmd_done = 1'b0;
            nxt.sck      = 1'b0;
            nxt.mosi     = nxt.sr[CMD_BITS-1];
        end
        else
        begin
            unique case (cur.st)
                FDE_RD_IDLE:
                begin
                    nxt.ss_n = 1'b1;
                    nxt.sck  = 1'b0;
                end
                FDE_RD_SHIFT:
                begin
                    nxt.ss_n = 1'b0;
                    if (cur.ph == PH_LAST)
                    begin
                        // flash answers msb first on each clock
                        nxt.sr   = {cur.sr[CMD_BITS-2:0],
                                    cur.miso_sync}; // see [R9] see [R21]
                        nxt.mosi = cur.sr[CMD_BITS-2]; // see [R8]
                        nxt.ph   = '0;
                        nxt.bits = cur.bits + 1'b1;
                        if (!cur.cmd_done && cur.bits == CMD_LAST)
                        begin
                            nxt.cmd_done = 1'b1;
                            nxt.bits     = '0;
                        end
                        else if (cur.cmd_done && cur.bits == BYTE_LAST)
                        begin
                            nxt.bits  = '0;
                            nxt.st    = FDE_RD_HALT; // see [R10]
                            nxt.bytes = cur.bytes + 1'b1;
                        end
                    end
                    else
                    begin
                        nxt.ph = cur.ph + 1'b1;
                    end
                    // one clock pulse in the second half of each bit
                    nxt.sck = nxt.ph >= PH_HALF; // see [R8]
                end
                FDE_RD_HALT:
                begin
                    nxt.sck = 1'b0;
                    if (resume)
                    begin
                        nxt.st = FDE_RD_SHIFT; // see [R10]
                    end
                end
                default:
                begin
                    nxt.st = FDE_RD_IDLE;
                end
            endcase
        end
        nxt.rdy = nxt.st == FDE_RD_HALT;
    end

    always_ff @(posedge clk_sys or posedge reset)
    begin
        if (reset)
        begin
            cur      <= '0; // see [R20]
            cur.st   <= FDE_RD_IDLE;
            cur.ss_n <= 1'b1;
        end
        else
        begin
            cur <= nxt;
        end
    end

    assign data_byte  = cur.sr[BYTE_BITS-1:0]; // see [R9]
    assign byte_ready = cur.rdy;
    assign spi_ss_n   = cur.ss_n;
    assign spi_sck    = cur.sck;
    assign spi_mosi   = cur.mosi;

endmodule

// ---- verilog/fde_top.sv ----
// floppy disk emulator: slot latch, track stream and drive noise mixer
`timescale 1ns/1ps

// Notes on behaviour
// [R1] eight latch bits, each set or cleared by a processor read
// [R2] only the slot six io page is decoded for the latch bits
// [R3] phase order steps the head; two half steps make one track
// [R4] a track change raises a one-cycle new-track pulse
// [R5] flash start address moves by 5984 bytes per track
// [R6] a track is 16 sectors of 374 bytes, read via one address
// [R7] read request: select high one cycle, load command 03 and address
// [R8] shift left each bit, msb onto mosi, one clock pulse per shift
// [R9] miso enters the lsb; low eight bits form the disk byte
// [R10] after 32 command bits, halt every 8 bits until a data read
// [R11] after 5984 bytes the reader restarts the same track
// [R12] read only: nothing is ever written to the flash
// [R13] the speaker is one flip-flop toggled by each access
// [R14] mixer counter is 5 bits on processor ticks, wraps at 32
// [R15] counts 0-1 click, 2 spin noise, 3-31 speaker
// [R16] any phase rising edge gives a 2 ms click pulse
// [R17] 12-bit maximal lfsr stepped on mixer overflow
// [R18] lfsr moves on only 5 of every 8 overflows
// [R19] spin noise is anded with the motor-on latch bit
// [R20] reset clears latch, homes track, leaves reader idle
// [R21] flash returns bytes msb first while select stays low
module fde_top
    import fde_pkg::*;
#(
    parameter int unsigned CLICK_CYCLES = CLICK_CYC,
    parameter int unsigned BIT_CYC      = SPI_BIT_CYC,
    parameter int unsigned TRACK_MAX    = TRACK_LAST
)
(
    // clock and reset
    input  wire logic               clk_sys,
    input  wire logic               reset,
    // processor bus
    input  wire logic               cpu_tick,
    input  wire logic               cpu_strobe,
    input  wire logic               cpu_rd,
    input  wire logic [15:0]        cpu_addr,
    // disk data toward the processor
    output logic      [7:0]         disk_byte,
    output logic                    disk_ready,
    // controller state
    output logic      [7:0]         latch_bits,
    output logic      [TRACK_W-1:0] track_num,
    // audio
    output logic                    audio_out,
    // serial flash
    output logic                    spi_ss_n,
    output logic                    spi_sck,
    output logic                    spi_mosi,
    input  wire logic               spi_miso
);

    localparam int unsigned CLICK_W = $clog2(CLICK_CYCLES + 1);

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [7:0]         latch;
        logic               spk;
        logic [CLICK_W-1:0] click_cnt;
        logic [MIX_W-1:0]   mix_cnt;
        logic [2:0]         pre;
        logic [LFSR_W-1:0]  lfsr;
        logic               audio;
        logic               req;
    } fde_top_state_t;

    fde_top_state_t    cur;
    fde_top_state_t    nxt;
    logic              slot_hit;
    logic              data_rd;
    logic              spk_hit;
    logic              rd_req;
    logic              new_track;
    logic              click_on;
    logic              spin_noise;
    logic              mix_ovf;
    logic [PHASE_HI:0] phase_rise;
    logic [2:0]        lat_idx;
    logic [ADDR_W-1:0] flash_addr;

    // ------------------------------------------------------------------
    // decode
    // ------------------------------------------------------------------
    // latch reacts to reads only; the card never needed write cycles
    assign slot_hit = cpu_strobe && cpu_rd
                      && (cpu_addr & SLOT_IO_MASK) == SLOT_IO_BASE; // see [R2]
    assign data_rd  = slot_hit && cpu_addr == DISK_DATA_ADDR; // see [R6]
    assign spk_hit  = cpu_strobe
                      && (cpu_addr & SPK_MASK) == SPK_ADDR; // see [R13]
    assign lat_idx  = cpu_addr[LATCH_SEL_HI:LATCH_SEL_LO];
    assign rd_req   = cur.req || new_track;
    assign click_on = cur.click_cnt != '0;
    // prescaler and lfsr move on the tick that wraps the mixer count
    assign mix_ovf  = cpu_tick && cur.mix_cnt == MIX_LAST;
    assign spin_noise = cur.lfsr[LFSR_W-1] && cur.latch[LATCH_MOTOR]; // see [R19]

    // ------------------------------------------------------------------
    // next state
    // ------------------------------------------------------------------
    always_comb
    begin
        nxt = cur;
        if (slot_hit)
        begin
            nxt.latch[lat_idx] = cpu_addr[LATCH_VAL_BIT]; // see [R1]
        end
        if (spk_hit)
        begin
            nxt.spk = !cur.spk; // see [R13]
        end
        // motor switching on starts streaming the current track
        nxt.req = nxt.latch[LATCH_MOTOR] && !cur.latch[LATCH_MOTOR];
        phase_rise = nxt.latch[PHASE_HI:0] & ~cur.latch[PHASE_HI:0];
        if (|phase_rise)
        begin
            nxt.click_cnt = CLICK_W'(CLICK_CYCLES); // see [R16]
        end
        else if (click_on)
        begin
            nxt.click_cnt = cur.click_cnt - 1'b1;
        end
        if (cpu_tick)
        begin
            nxt.mix_cnt = cur.mix_cnt + 1'b1; // see [R14]
        end
        if (mix_ovf)
        begin
            nxt.pre = cur.pre + 1'b1;
            // skipping three of eight slows the noise period toward 5 Hz
            if (cur.pre < LFSR_RUN_STEPS)
            begin
                nxt.lfsr = {cur.lfsr[LFSR_W-2:0],
                            ^(cur.lfsr & LFSR_TAPS)}; // see [R17] see [R18]
            end
        end
        if (cur.mix_cnt <= MIX_TRACK_LAST)
        begin
            nxt.audio = click_on; // see [R15]
        end
        else if (cur.mix_cnt == MIX_SPIN)
        begin
            nxt.audio = spin_noise; // see [R15]
        end
        else
        begin
            nxt.audio = cur.spk; // see [R15]
        end
    end

    always_ff @(posedge clk_sys or posedge reset)
    begin
        if (reset)
        begin
            cur       <= '0;
            cur.latch <= LATCH_RESET; // see [R20]
            cur.lfsr  <= LFSR_SEED;
        end
        else
        begin
            cur <= nxt;
        end
    end

    assign latch_bits = cur.latch;
    assign audio_out  = cur.audio;

    // ------------------------------------------------------------------
    // track counter and flash reader
    // ------------------------------------------------------------------
    fde_track_counter #(
        .TRACK_MAX  (TRACK_MAX)
    ) u_track (
        .clk_sys    (clk_sys),
        .reset      (reset),
        .phases     (cur.latch[PHASE_HI:0]),
        .track_num  (track_num),
        .flash_addr (flash_addr),
        .new_track  (new_track)
    );

    // the reader only drives select, clock and mosi; no write path
    fde_flash_reader #(
        .BIT_CYC    (BIT_CYC)
    ) u_reader (
        .clk_sys    (clk_sys),
        .reset      (reset),
        .rd_req     (rd_req),
        .start_addr (flash_addr),
        .resume     (data_rd),
        .data_byte  (disk_byte),
        .byte_ready (disk_ready),
        .spi_ss_n   (spi_ss_n),
        .spi_sck    (spi_sck),
        .spi_mosi   (spi_mosi),
        .spi_miso   (spi_miso)
    ); // see [R12]

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (reset);

    sequence s_rd_issue;
        rd_req;
    endsequence
    sequence s_ss_pulse;
        spi_ss_n ##1 !spi_ss_n;
    endsequence
    // a track change may legally reload the reader out of a halt
    sequence s_halted_wait;
        disk_ready && !data_rd && !rd_req;
    endsequence

    AST_LATCH_SET: // see [R1]
    assert property (slot_hit |=> latch_bits[$past(lat_idx)]
                     == $past(cpu_addr[LATCH_VAL_BIT]))
        else $error("latch bit did not follow the read address");

    AST_SLOT_ONLY: // see [R2]
    assert property (!slot_hit |=> latch_bits == $past(latch_bits))
        else $error("latch changed without a slot six read");

    AST_NEW_TRACK: // see [R4] see [R5]
    assert property (track_num != $past(track_num) |->
                     new_track && (flash_addr == $past(flash_addr)
                     + TRACK_BYTES || flash_addr == $past(flash_addr)
                     - TRACK_BYTES))
        else $error("track change without pulse or 5984 step");

    AST_SS_PULSE: // see [R7]
    assert property (s_rd_issue |=> s_ss_pulse)
        else $error("select not high for exactly one cycle");

    AST_HALT_HOLD: // see [R10] see [R9]
    assert property (s_halted_wait |=> disk_ready && !spi_sck
                     && disk_byte == $past(disk_byte))
        else $error("reader moved while waiting for a data read");

    AST_SPK_TOGGLE: // see [R13]
    assert property (spk_hit |=> cur.spk != $past(cur.spk))
        else $error("speaker did not toggle on access");

    AST_MIX_WRAP: // see [R14]
    assert property (mix_ovf |=> cur.mix_cnt == '0)
        else $error("mixer counter did not wrap at 32");

    AST_MIX_CLICK: // see [R15]
    assert property (cur.mix_cnt <= MIX_TRACK_LAST |=>
                     audio_out == $past(click_on))
        else $error("click slot not routed to audio");

    AST_MIX_SPIN: // see [R15] see [R19]
    assert property (cur.mix_cnt == MIX_SPIN |=>
                     audio_out == ($past(cur.lfsr[LFSR_W-1])
                     && $past(latch_bits[LATCH_MOTOR])))
        else $error("spin slot not gated noise");

    AST_MIX_SPK: // see [R15]
    assert property (cur.mix_cnt > MIX_SPIN |=>
                     audio_out == $past(cur.spk))
        else $error("speaker slot not routed to audio");

    AST_CLICK_START: // see [R16]
    assert property ((|phase_rise) |=> click_on [*8])
        else $error("click pulse did not start on a phase edge");

    AST_CLICK_END: // see [R16]
    assert property (cur.click_cnt == CLICK_W'(1) && !(|phase_rise)
                     |=> !click_on)
        else $error("click pulse longer than its length");

    AST_LFSR_RUN: // see [R17] see [R18]
    assert property (mix_ovf && cur.pre < LFSR_RUN_STEPS |=>
                     cur.lfsr != $past(cur.lfsr))
        else $error("lfsr did not advance on an active overflow");

    AST_LFSR_SKIP: // see [R18]
    assert property ((!mix_ovf || cur.pre >= LFSR_RUN_STEPS) |=>
                     cur.lfsr == $past(cur.lfsr))
        else $error("lfsr advanced in a skipped slot");

    AST_TRACK_PULSE: // see [R4]
    assert property (new_track |-> track_num != $past(track_num))
        else $error("new-track pulse without a track change");

    AST_SPK_HOLD: // see [R13]
    assert property (!spk_hit |=> cur.spk == $past(cur.spk))
        else $error("speaker changed without an access");

    AST_MIX_STEP: // see [R14]
    assert property (cpu_tick |=> cur.mix_cnt == $past(cur.mix_cnt) + 1'b1)
        else $error("mixer counter did not step on a tick");

    AST_MIX_HOLD: // see [R14]
    assert property (!cpu_tick |=> cur.mix_cnt == $past(cur.mix_cnt))
        else $error("mixer counter moved without a tick");

endmodule

// ---- dv/fde_flash_model.sv ----
// behavioural serial flash holding a simple address-derived byte pattern
`timescale 1ns/1ps

module fde_flash_model
(
    // flash pins
    input  wire logic spi_ss_n,
    input  wire logic spi_sck,
    input  wire logic spi_mosi,
    output logic      spi_miso
);
    logic [31:0] cmd;
    logic [23:0] addr;
    int unsigned nbit;
    int unsigned k;

    initial spi_miso = 1'b0;

    // a released line shows the inverse of its last value, never a hold
    always @(posedge spi_ss_n)
    begin
        nbit = 0;
        spi_miso = ~spi_miso;
    end

    always @(posedge spi_sck)
    begin
        if (!spi_ss_n)
        begin
            if (nbit < 32)
                cmd = {cmd[30:0], spi_mosi};
            nbit++;
        end
    end

    // byte at a is a[7:0]^a[15:8], msb first, changed on sck fall
    always @(negedge spi_sck)
    begin
        if (!spi_ss_n && nbit >= 32)
        begin
            k = nbit - 32;
            addr = cmd[23:0] + 24'(k / 8);
            spi_miso = addr[7 - k % 8] ^ addr[15 - k % 8];
        end
    end
endmodule

// ---- dv/fde_top_test.sv ----
// self-checking bench for the floppy emulator top
`timescale 1ns/1ps

`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin \
    $display("[ERR] %s exp %h got %h", n, e, g); err_count++; end end

module fde_top_test;
    import fde_pkg::*;
    localparam int unsigned CLK_N = 20;
    logic               clk_sys    = 1'b0;
    logic               reset      = 1'b1;
    logic               cpu_tick   = 1'b0;
    logic               cpu_strobe = 1'b0;
    logic               cpu_rd     = 1'b0;
    logic [15:0]        cpu_addr   = 16'h0000;
    logic [7:0]         disk_byte;
    logic [7:0]         latch_bits;
    logic [TRACK_W-1:0] track_num;
    logic               disk_ready;
    logic               audio_out;
    logic               spi_ss_n;
    logic               spi_sck;
    logic               spi_mosi;
    logic               spi_miso;
    int                 err_count  = 0;
    int                 tests_run  = 0;
    int                 cyc        = 0;

    always #20 clk_sys = ~clk_sys;

    fde_top #(.CLICK_CYCLES(CLK_N), .BIT_CYC(8), .TRACK_MAX(34)) fde_top_i
    (
        .clk_sys(clk_sys), .reset(reset), .cpu_tick(cpu_tick),
        .cpu_strobe(cpu_strobe), .cpu_rd(cpu_rd), .cpu_addr(cpu_addr),
        .disk_byte(disk_byte), .disk_ready(disk_ready),
        .latch_bits(latch_bits), .track_num(track_num),
        .audio_out(audio_out), .spi_ss_n(spi_ss_n), .spi_sck(spi_sck),
        .spi_mosi(spi_mosi), .spi_miso(spi_miso)
    );

    fde_flash_model fde_flash_model_i
    (
        .spi_ss_n(spi_ss_n), .spi_sck(spi_sck),
        .spi_mosi(spi_mosi), .spi_miso(spi_miso)
    );

    // ------------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------------
    task automatic stop_test;
        $display("comparisons %0d mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    always @(posedge clk_sys)
    begin
        cyc++;
        if (cyc == 60000)
        begin
            err_count++;
            $display("[ERR] cycles exp %0d got %0d", 59999, cyc);
            stop_test();
        end
    end

    task automatic idle(input int n);
        repeat (n) @(posedge clk_sys);
        #2;
    endtask

    task automatic acc(input logic [15:0] a, input logic rd);
        @(posedge clk_sys);
        #2;
        cpu_strobe = 1'b1;
        cpu_rd = rd;
        cpu_addr = a;
        @(posedge clk_sys);
        #2;
        cpu_strobe = 1'b0;
    endtask

    task automatic tick(input int n);
        repeat (n)
        begin
            @(posedge clk_sys);
            #2;
            cpu_tick = 1'b1;
            @(posedge clk_sys);
            #2;
            cpu_tick = 1'b0;
        end
    endtask

    // wait for a halted byte, compare it, then resume with a data read
    task automatic get_byte(input logic [23:0] a);
        int k;
        k = 0;
        idle(6);
        while (disk_ready !== 1'b1 && k < 2000)
        begin
            idle(1);
            k++;
        end
        `CHK("disk_ready", 1'b1, disk_ready)
        `CHK("disk_byte", a[7:0] ^ a[15:8], disk_byte)
        acc(16'hc0ec, 1'b1);
    endtask

    // ------------------------------------------------------------------
    // tests
    // ------------------------------------------------------------------
    initial
    begin
        idle(5);
        reset = 1'b0;
        idle(1);
        `CHK("latch", 8'h00, latch_bits)
        `CHK("ss_n", 1'b1, spi_ss_n)
        `CHK("track", 6'h00, track_num)
        for (int i = 5; i < 8; i++)
        begin
            acc({12'hc0e, 3'(i), 1'b1}, 1'b1);
            idle(1);
            `CHK("latch bit", 1'b1, latch_bits[i])
        end
        acc(16'hc0ea, 1'b0);
        acc(16'hc0da, 1'b1);
        idle(1);
        `CHK("latch", 8'he0, latch_bits)
        acc(16'hc0ea, 1'b1);
        acc(16'hc0ee, 1'b1);
        acc(16'hc0ec, 1'b1);
        idle(1);
        `CHK("latch", 8'h00, latch_bits)
        $display("test latch done");
        acc(16'hc0e9, 1'b1);
        for (int b = 0; b < 3; b++)
            get_byte(24'(b));
        `CHK("ss_n", 1'b0, spi_ss_n)
        $display("test stream done");
        acc(16'hc0e3, 1'b1);
        acc(16'hc0e2, 1'b1);
        acc(16'hc0e5, 1'b1);
        idle(2);
        `CHK("track", 6'h01, track_num)
        get_byte(24'd5984);
        acc(16'hc0e4, 1'b1);
        acc(16'hc0e3, 1'b1);
        idle(2);
        `CHK("track", 6'h00, track_num)
        get_byte(24'd0);
        $display("test track done");
        tick(3);
        acc(16'hc030, 1'b0);
        idle(2);
        `CHK("audio", 1'b1, audio_out)
        acc(16'hc030, 1'b1);
        idle(2);
        `CHK("audio", 1'b0, audio_out)
        tick(29);
        idle(CLK_N + 2);
        `CHK("audio", 1'b0, audio_out)
        acc(16'hc0e7, 1'b1);
        idle(3);
        `CHK("audio", 1'b1, audio_out)
        idle(CLK_N + 2);
        `CHK("audio", 1'b0, audio_out)
        $display("test audio done");
        stop_test();
    end
endmodule
